//--- ldosc_params.svh
`ifndef LDOSC_PARAMS_SVH
`define LDOSC_PARAMS_SVH

// register addresses on the internal register port
`define LDOSC_ADDR_AOP 8'h3d
`define LDOSC_ADDR_MEMP 8'h3e
`define LDOSC_ADDR_DEVS 8'h41
`define LDOSC_ADDR_M1V8 8'h43
`define LDOSC_ADDR_AON 8'h45
`define LDOSC_ADDR_PANEL 8'h46
`define LDOSC_ADDR_WIRELESS 8'h4c

// reset values
`define LDOSC_RST_AOP 6'h07
`define LDOSC_RST_MEMP 6'h3c
`define LDOSC_RST_DEVS 6'h07
`define LDOSC_RST_M1V8 6'h3c
`define LDOSC_RST_AON 6'h07
`define LDOSC_RST_PANEL 6'h24
`define LDOSC_RST_WIRELESS 6'h24

// field layout
`define LDOSC_STATE_LSB 0
`define LDOSC_STATE_MSB 2
`define LDOSC_EXIT_LSB 3
`define LDOSC_EXIT_MSB 5
`define LDOSC_CODE_VALID_BIT 2
`define LDOSC_NUM_RAILS 7

`endif

//--- ldosc_pkg.sv
`default_nettype none
package ldosc_pkg;

  // regulator operating mode decoded from a state field
  typedef enum logic [1:0] {
    LDOSC_MODE_OFF = 2'h0,
    LDOSC_MODE_LOWPWR = 2'h1,
    LDOSC_MODE_ACTIVE = 2'h3,
    LDOSC_MODE_RSVD = 2'h2
  } ldosc_mode_e;

  // register write/read port
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ldosc_req_s;

  // live and queued fields of one rail
  typedef struct packed {
    logic [2:0] exit_state;
    logic [2:0] state;
  } ldosc_ctrl_s;

endpackage
`default_nettype wire

//--- ldosc_bank.sv
// Notes on behaviour
// R01 - code 4 off, code 5 low power
// R02 - codes 6 and 7 both mean active
// R03 - host never writes state codes 0 to 3
// R04 - exit pin loads state from exit field
// R05 - exit codes 0 to 3 leave state alone
// R06 - host programs exit fields before relying on them
// R07 - 1.8 V rail at 0x43, reset 0x3c
// R08 - panel rail at 0x46, reset 0x24
// R09 - device-supply rail at 0x41, reset 0x07
// R10 - wireless rail at 0x4c, reset 0x24
// R11 - always-on-processor rail at 0x3d, reset 0x07
// R12 - memory-processor rail at 0x3e, reset 0x3c
// R13 - always-on rail at 0x45, reset 0x07
// R14 - each register controls only its rail
// R15 - bits 7:6 read zero, writes ignored
// R16 - one copy per exit rising edge; write wins
`timescale 1ns/1ps
`default_nettype none
`include "ldosc_params.svh"

module ldosc_bank (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire ldosc_pkg::ldosc_req_s req_i,
  input wire logic standby_exit_pin_i,
  output logic [7:0] rdata_o,
  output logic hit_o,
  output logic [13:0] rail_mode_o,
  output logic [6:0] rail_on_o
);

  // rail order: 0 1.8 V, 1 panel, 2 device supply, 3 wireless,
  // 4 always-on processor, 5 memory processor, 6 always-on
  localparam logic [7:0] ADDR [0:6] = '{`LDOSC_ADDR_M1V8, `LDOSC_ADDR_PANEL,
    `LDOSC_ADDR_DEVS, `LDOSC_ADDR_WIRELESS, `LDOSC_ADDR_AOP,
    `LDOSC_ADDR_MEMP, `LDOSC_ADDR_AON};
  localparam logic [5:0] RST [0:6] = '{`LDOSC_RST_M1V8, `LDOSC_RST_PANEL,
    `LDOSC_RST_DEVS, `LDOSC_RST_WIRELESS, `LDOSC_RST_AOP,
    `LDOSC_RST_MEMP, `LDOSC_RST_AON};

  logic exit_meta;
  logic exit_sync;
  logic exit_prev;
  wire exit_rise;
  ldosc_pkg::ldosc_ctrl_s ctrl [0:6];
  logic [6:0] sel;
  logic [7:0] next_rdata;

  // two-flop synchroniser and edge detect on the exit pin
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      exit_meta <= 1'b0;
      exit_sync <= 1'b0;
      exit_prev <= 1'b0;
    end else begin
      exit_meta <= standby_exit_pin_i;
      exit_sync <= exit_meta;
      exit_prev <= exit_sync;
    end
  end

  assign exit_rise = exit_sync & ~exit_prev; // [R16]

  genvar g;
  generate
    for (g = 0; g < `LDOSC_NUM_RAILS; g++) begin : g_rail
      wire wr_hit;
      wire exit_copy;
      ldosc_pkg::ldosc_mode_e mode;

      assign sel[g] = (req_i.addr == ADDR[g]); // [R07] [R08] [R09] [R10] [R11] [R12] [R13]
      assign wr_hit = req_i.wr & sel[g]; // [R14]
      // copy only when the queued code has its top bit set
      assign exit_copy = exit_rise & ctrl[g].exit_state[`LDOSC_CODE_VALID_BIT]; // [R04] [R05]

      // host write wins over the standby-exit copy
      always_ff @(posedge mclk_i) begin
        if (reset_i) begin
          ctrl[g] <= RST[g]; // [R07] [R08] [R09] [R10] [R11] [R12] [R13]
        end else if (wr_hit) begin
          ctrl[g].state <= req_i.wdata[`LDOSC_STATE_MSB:`LDOSC_STATE_LSB]; // [R15] [R16]
          ctrl[g].exit_state <= req_i.wdata[`LDOSC_EXIT_MSB:`LDOSC_EXIT_LSB];
        end else if (exit_copy) begin
          ctrl[g].state <= ctrl[g].exit_state; // [R04]
        end
      end

      // decode live field into an operating mode
      always_comb begin
        case (ctrl[g].state)
          3'h4: mode = ldosc_pkg::LDOSC_MODE_OFF; // [R01]
          3'h5: mode = ldosc_pkg::LDOSC_MODE_LOWPWR; // [R01]
          3'h6, 3'h7: mode = ldosc_pkg::LDOSC_MODE_ACTIVE; // [R02]
          default: mode = ldosc_pkg::LDOSC_MODE_RSVD; // reserved codes, undefined
        endcase
      end

      assign rail_mode_o[2*g+1:2*g] = mode;
      assign rail_on_o[g] = mode[0]; // low power or active
    end
  endgenerate

  // read mux, upper bits zero
  always_comb begin
    next_rdata = 8'h00;
    for (int i = 0; i < `LDOSC_NUM_RAILS; i++) begin
      if (sel[i]) begin
        next_rdata = {2'h0, ctrl[i]}; // [R15]
      end
    end
  end

  assign hit_o = |sel;

  // registered read data
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      rdata_o <= 8'h00;
    end else if (req_i.rd) begin
      rdata_o <= next_rdata;
    end
  end

endmodule

`default_nettype wire

//--- ldosc_bank_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ldosc_bank_asserts (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire ldosc_pkg::ldosc_req_s req_i,
  input wire logic standby_exit_pin_i,
  input wire logic [7:0] rdata_o,
  input wire logic hit_o,
  input wire logic [13:0] rail_mode_o,
  input wire logic [6:0] rail_on_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  // write to the 1v8 rail and its state code
  wire logic w = req_i.wr && req_i.addr == 8'h43;
  wire logic [2:0] s = req_i.wdata[2:0];
  wire logic [1:0] m = rail_mode_o[1:0];
  top_zero_a: assert property (req_i.rd |=> rdata_o[7:6] == 2'h0) else $error("top bits");
  miss_zero_a: assert property (req_i.rd && !hit_o |=> rdata_o == 8'h00) else $error("miss");
  off_code_a: assert property (w && s == 3'h4 |=> m == 2'h0) else $error("off");
  low_code_a: assert property (w && s == 3'h5 |=> m == 2'h1) else $error("low");
  act_code_a: assert property (w && s[2:1] == 2'h3 |=> m == 2'h3) else $error("active");
  rail_on_a: assert property (rail_on_o[0] == (m inside {2'h1, 2'h3})) else $error("on");
  hit_map_a: assert property (hit_o == (req_i.addr inside {8'h3d, 8'h3e, 8'h41, 8'h43, 8'h45, 8'h46, 8'h4c}))
    else $error("hit");
  rail_iso_a: assert property (w && !standby_exit_pin_i && !$past(standby_exit_pin_i, 3)
    |=> $stable(rail_mode_o[13:2])) else $error("isolation");
endmodule
bind ldosc_bank ldosc_bank_asserts u_ldosc_bank_asserts (.mclk_i, .reset_i, .req_i, .standby_exit_pin_i,
  .rdata_o, .hit_o, .rail_mode_o, .rail_on_o);
`default_nettype wire

//--- ldosc_host.sv
`timescale 1ns/1ps
`default_nettype none
module ldosc_host (
  input wire logic mclk_i,
  output var ldosc_pkg::ldosc_req_s req_o,
  output var logic pin_o
);
  initial req_o = '0;
  initial pin_o = 1'b0;
  // one-cycle strobe; state codes kept within 4 to 7
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    req_o = {wr, !wr, a, d | 8'h04};
    @(negedge mclk_i);
    req_o = '0;
  endtask
  // exit pin held high for six cycles
  task automatic pulse();
    @(negedge mclk_i);
    pin_o = 1'b1;
    repeat (6) @(negedge mclk_i);
    pin_o = 1'b0;
  endtask
endmodule
`default_nettype wire

//--- ldosc_bank_bench.sv
`timescale 1ns/1ps
`default_nettype none
module ldosc_bank_bench;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  ldosc_pkg::ldosc_req_s req_i;
  logic standby_exit_pin_i;
  logic [7:0] rdata_o;
  logic hit_o;
  logic [13:0] rail_mode_o;
  logic [6:0] rail_on_o;
  logic [31:0] r = 32'h00017b38;
  logic [7:0] adr [7] = '{8'h43, 8'h46, 8'h41, 8'h4c, 8'h3d, 8'h3e, 8'h45};
  logic [5:0] e [7] = '{6'h3c, 6'h24, 6'h07, 6'h24, 6'h07, 6'h3c, 6'h07};
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  initial forever #2.5 mclk_i = ~mclk_i;
  ldosc_host u_ldosc_host (.mclk_i, .req_o(req_i), .pin_o(standby_exit_pin_i));
  ldosc_bank u_ldosc_bank (.mclk_i, .reset_i, .req_i, .standby_exit_pin_i, .rdata_o, .hit_o, .rail_mode_o, .rail_on_o);
  function automatic logic [7:0] md(input logic [2:0] s);
    return s[1] ? 8'h03 : {7'h0, s[0]};
  endfunction
  task automatic chk(input string n, input logic [7:0] x, input logic [7:0] y);
    compares++;
    if (x !== y) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", n, x, y);
    end
  endtask
  // read back every register and its decoded mode
  task automatic sweep();
    for (int i = 0; i < 7; i++) begin
      u_ldosc_host.xfer(1'b0, adr[i], 8'h00);
      chk("rdata", {2'h0, e[i]}, rdata_o);
      chk("mode", md(e[i][2:0]), {6'h0, rail_mode_o[2*i+:2]});
      chk("on", {7'h0, e[i][1] | e[i][0]}, {7'h0, rail_on_o[i]});
    end
  endtask
  task automatic summarize();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      summarize();
    end
  end
  initial begin
    int i;
    repeat (20) @(posedge mclk_i);
    @(negedge mclk_i) reset_i = 1'b0;
    sweep();
    u_ldosc_host.xfer(1'b0, 8'h47, 8'h00);
    chk("miss", 8'h00, rdata_o);
    u_ldosc_host.xfer(1'b1, 8'h47, 8'hff);
    // state codes 4 to 7 on the 1v8 rail, top bits set
    for (int c = 4; c < 8; c++) begin
      u_ldosc_host.xfer(1'b1, 8'h43, {5'h1f, c[2:0]});
      e[0] = {3'h7, c[2:0]};
      sweep();
    end
    for (int j = 0; j < 5; j++) begin
      for (int k = 0; k < 10; k++) begin
        r ^= r << 13;
        r ^= r >> 17;
        r ^= r << 5;
        i = r[7:0] % 7;
        u_ldosc_host.xfer(1'b1, adr[i], r[15:8]);
        e[i] = r[13:8] | 6'h04;
      end
      sweep();
      u_ldosc_host.pulse();
      for (int q = 0; q < 7; q++)
        if (e[q][5]) e[q][2:0] = e[q][5:3];
      sweep();
    end
    summarize();
  end
endmodule
`default_nettype wire
